// >>> serial_bridge_pkg.sv
// Constants, register map and state types for the parallel-to-serial peripheral bridge.
// Assumes a single 250 MHz system clock shared by both ends.
//
// How it works
// - Sample format pin after reset; low means shared bus
// - Host holds format pin low when sharing bus
// - Separate four-bit address, eight-bit data bus
// - Select high: strobes ignored, data bus released
// - Address latched while address strobe is high
// - Host ties strobe-style pin on separate bus
// - Strobe polarity and direction follow strobe style
// - Master reset pin gives full reset state
// - Format pin pulls low on transfer done, separate bus only
// - Port register writes drive select pins directly
// - Alias access runs select, shift, deselect sequence
// - First byte at 01h, second at 00h
// - Aliases 02h..09h hit first byte, pick select
// - One shared pair of data byte registers
// - Shift clock divided from system clock
// - Shifting starts after write strobe trailing edge
// - Per-device bit picks 8 or 16 clocks
// - Divide code sets clock divide by power two
// - Done status bit reads 0 while shifting
`default_nettype none

package serial_bridge_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] A_SECOND  = 4'h0;
  localparam logic [3:0] A_FIRST   = 4'h1;
  localparam logic [3:0] A_ALIAS0  = 4'h2;
  localparam logic [3:0] A_ALIAS7  = 4'h9;
  localparam logic [3:0] A_SELPORT = 4'ha;
  localparam logic [3:0] A_POLAR   = 4'hb;
  localparam logic [3:0] A_WORDLEN = 4'hc;
  localparam logic [3:0] A_RATE    = 4'hd;
  localparam logic [3:0] A_STATUS  = 4'he;
  localparam logic [3:0] A_PINDEF  = 4'hf;

  // ==========================================================
  // Field positions and reset values
  localparam int         RATE_INTEN_BIT = 7;
  localparam int         STATUS_DONE_BIT = 7;
  localparam logic [7:0] SELPORT_RST = 8'hff;
  localparam logic [7:0] PINDEF_RST  = 8'hff;
  localparam logic [7:0] POLAR_RST   = 8'h00;
  localparam logic [7:0] WORDLEN_RST = 8'h00;
  localparam logic [2:0] SW_DEV      = 3'h7;

  // ==========================================================
  // Timing
  localparam int         CLK_NS        = 4;
  localparam int         HOST_PHASE_NS = 32;
  localparam int         HOST_PHASE_CYC = (HOST_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] FMT_SAMPLE_CYC = 2'h3;

  // ==========================================================
  // State types
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEL  = 3'b001,
    S_HI   = 3'b010,
    S_LO   = 3'b011,
    S_END  = 3'b100
  } shift_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ALE  = 3'b001,
    H_GAP  = 3'b010,
    H_STB  = 3'b011,
    H_REC  = 3'b100
  } host_state_e;

endpackage

`default_nettype wire

// >>> serial_bridge_if.sv
// Pin-level carrier between the host bus end and the bridge device end.
// Resolves the shared data bus and the pulled-up format/interrupt pin from the enables.
`default_nettype none

interface serial_bridge_if;
  logic [7:0] ad_host_o;
  logic       ad_host_oe;
  logic [7:0] ad_dev_o;
  logic       ad_dev_oe;
  logic [7:0] ad;
  logic [3:0] addr_lines;
  logic       chip_en_n;
  logic       wr_pin;
  logic       read_or_data_strobe;
  logic       addr_strobe_bus_type;
  logic       master_reset_n;
  logic       fmt_host_oe;
  logic       fmt_dev_oe;
  logic       bus_format_irq_pin;

  // Undriven data reads as all ones; the format pin has a pull-up
  assign ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : 8'hff);
  assign bus_format_irq_pin = ~(fmt_host_oe | fmt_dev_oe);

  modport dev (
    input  ad, addr_lines, chip_en_n, wr_pin, read_or_data_strobe,
    input  addr_strobe_bus_type, master_reset_n, bus_format_irq_pin,
    output ad_dev_o, ad_dev_oe, fmt_dev_oe
  );

  modport host (
    input  ad, bus_format_irq_pin,
    output ad_host_o, ad_host_oe, addr_lines, chip_en_n, wr_pin,
    output read_or_data_strobe, addr_strobe_bus_type, master_reset_n, fmt_host_oe
  );
endinterface

`default_nettype wire

// >>> sk_divider.sv
// Programmable half-period tick generator for the serial shift clock.
// Assumes run is driven from logic on the same clock.
`default_nettype none

module sk_divider
  import serial_bridge_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] divide_code,
  // Half-period tick
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_s;

  div_s s_r;
  div_s s_nxt;
  logic [6:0] lim;

  assign tick = s_r.tick;
  // Half period is 2^(code-1) clocks; code 0 cannot beat clk/2 and runs as code 1
  assign lim  = (divide_code == 3'h0) ? 7'h00 : (7'h01 << (divide_code - 3'h1)) - 7'h01;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = 7'h00;
    end else if (s_r.cnt >= lim) begin
      s_nxt.cnt  = 7'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> serial_periph_bridge_dev.sv
// Device end: parallel host bus slave with eight-way serial peripheral master.
// Assumes bus pins are asynchronous to clk and are synchronised here.
`default_nettype none

module serial_periph_bridge_dev
  import serial_bridge_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       resetn,
  // Host bus pins
  serial_bridge_if.dev    bus,
  // Board strap: strobe style on the shared bus, 1 selects data strobe with direction
  input  wire logic       mux_moto_style,
  // Peripheral select pins
  output logic [7:0]      peripheral_select_pins_o,
  output logic [7:0]      peripheral_select_pins_oe,
  input  wire logic [7:0] peripheral_select_pins_i,
  // Serial data and clock
  output logic            serial_shift_clock,
  output logic            serial_out,
  input  wire logic       serial_in
);

  typedef struct packed {
    logic [7:0] ad;
    logic [3:0] a;
    logic       ce_n;
    logic       wr;
    logic       rd;
    logic       as;
    logic       fmt;
    logic       mrst_n;
    logic       si;
    logic       mstyle;
    logic [7:0] pins;
  } sync_s;

  typedef struct packed {
    sync_s        sy1;
    sync_s        sy2;
    logic [1:0]   fmt_cnt;
    logic         fmt_done;
    logic         mux;
    logic [3:0]   addr;
    logic         wr_pend;
    logic [3:0]   waddr;
    logic [7:0]   wdata;
    logic [7:0]   second;
    logic [7:0]   first;
    logic [7:0]   selport;
    logic [7:0]   pindef;
    logic [7:0]   polar;
    logic [7:0]   wordlen;
    logic         inten;
    logic [2:0]   divide_code;
    logic         done;
    logic         irq;
    shift_state_e st;
    logic         hw;
    logic [2:0]   dev;
    logic         len16;
    logic [4:0]   bits;
    logic [15:0]  sh;
    logic         skh;
    logic [7:0]   dout;
    logic         doe;
    logic [7:0]   sel_o;
    logic [7:0]   sel_oe;
    logic         sk_o;
    logic         so;
    logic         irq_oe;
  } dev_s;

  localparam dev_s ST_RST = '{
    sy1: '0, sy2: '0, fmt_cnt: 2'h0, fmt_done: 1'b0, mux: 1'b0,
    addr: 4'h0, wr_pend: 1'b0, waddr: 4'h0, wdata: 8'h00,
    second: 8'h00, first: 8'h00, selport: SELPORT_RST, pindef: PINDEF_RST,
    polar: POLAR_RST, wordlen: WORDLEN_RST, inten: 1'b0, divide_code: 3'h0,
    done: 1'b1, irq: 1'b0, st: S_IDLE, hw: 1'b0, dev: 3'h0, len16: 1'b0,
    bits: 5'h00, sh: 16'h0000, skh: 1'b0, dout: 8'h00, doe: 1'b0,
    sel_o: SELPORT_RST, sel_oe: ~PINDEF_RST, sk_o: 1'b0, so: 1'b0, irq_oe: 1'b0
  };

  dev_s s_r;
  dev_s s_nxt;
  logic tick;

  // ==========================================================
  // Register read data
  function automatic logic [7:0] reg_read(input logic [3:0] a, input dev_s s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      A_SECOND:  v = s.second;
      A_SELPORT: v = (s.pindef & s.sy2.pins) | ~s.pindef;
      A_STATUS:  v = {s.done, 7'h00};
      default: begin
        if (a >= A_FIRST && a <= A_ALIAS7) begin
          v = s.first;
        end
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // Shift clock divider
  sk_divider u_div (
    .clk         (clk),
    .resetn      (resetn),
    .run         (s_r.st != S_IDLE),
    .divide_code (s_r.divide_code),
    .tick        (tick)
  );

  assign bus.ad_dev_o              = s_r.dout;
  assign bus.ad_dev_oe             = s_r.doe;
  assign bus.fmt_dev_oe            = s_r.irq_oe;
  assign peripheral_select_pins_o  = s_r.sel_o;
  assign peripheral_select_pins_oe = s_r.sel_oe;
  assign serial_shift_clock        = s_r.sk_o;
  assign serial_out                = s_r.so;

  // ==========================================================
  // Next state
  always_comb begin
    sync_s      p;
    sync_s      raw;
    logic       sel;
    logic       moto;
    logic       rd_act;
    logic       wr_act;
    logic [3:0] ca;
    logic [2:0] di;
    p = s_r.sy2;
    raw = '{ad: bus.ad, a: bus.addr_lines, ce_n: bus.chip_en_n, wr: bus.wr_pin,
            rd: bus.read_or_data_strobe, as: bus.addr_strobe_bus_type,
            fmt: bus.bus_format_irq_pin, mrst_n: bus.master_reset_n, si: serial_in,
            mstyle: mux_moto_style, pins: peripheral_select_pins_i};
    s_nxt = s_r;
    s_nxt.sy1 = raw;
    s_nxt.sy2 = s_r.sy1;
    sel    = ~p.ce_n & s_r.fmt_done;
    moto   = s_r.mux ? p.mstyle : ~p.as;
    rd_act = moto ? (p.rd & p.wr) : ~p.rd;
    wr_act = moto ? (p.rd & ~p.wr) : ~p.wr;
    ca     = s_r.mux ? s_r.addr : p.a;
    di     = 3'h0;

    // Format strap is caught once, after the synchroniser has filled
    if (!s_r.fmt_done) begin
      if (s_r.fmt_cnt == FMT_SAMPLE_CYC) begin
        s_nxt.fmt_done = 1'b1;
        s_nxt.mux      = ~p.fmt;
      end else begin
        s_nxt.fmt_cnt = s_r.fmt_cnt + 2'h1;
      end
    end

    if (sel && s_r.mux && p.as) begin
      s_nxt.addr = p.ad[3:0];
    end

    // Reads drive the bus only while selected and strobed
    s_nxt.doe  = sel & rd_act & ~(s_r.mux & p.as);
    // Read data is frozen for the whole strobe so a status change cannot tear it
    s_nxt.dout = s_r.doe ? s_r.dout : reg_read(ca, s_r);
    if (sel && rd_act && ca == A_STATUS) begin
      s_nxt.irq = 1'b0;
    end

    // Writes take effect on the trailing edge of the strobe
    if (sel && wr_act) begin
      s_nxt.wr_pend = 1'b1;
      s_nxt.waddr   = ca;
      s_nxt.wdata   = p.ad;
    end else if (s_r.wr_pend) begin
      s_nxt.wr_pend = 1'b0;
      case (s_r.waddr)
        A_SECOND:  if (s_r.st == S_IDLE) s_nxt.second = s_r.wdata;
        A_SELPORT: s_nxt.selport = s_r.wdata;
        A_POLAR:   s_nxt.polar = s_r.wdata;
        A_WORDLEN: s_nxt.wordlen = s_r.wdata;
        A_RATE: begin
          s_nxt.inten       = s_r.wdata[RATE_INTEN_BIT];
          s_nxt.divide_code = s_r.wdata[2:0];
        end
        A_PINDEF:  s_nxt.pindef = s_r.wdata;
        default: begin
          if (s_r.waddr >= A_FIRST && s_r.waddr <= A_ALIAS7 && s_r.st == S_IDLE) begin
            s_nxt.hw = (s_r.waddr != A_FIRST);
            di = (s_r.waddr == A_FIRST) ? SW_DEV : 3'(s_r.waddr - A_ALIAS0);
            s_nxt.dev   = di;
            s_nxt.first = s_r.wdata;
            s_nxt.len16 = s_r.wordlen[di];
            s_nxt.bits  = s_r.wordlen[di] ? 5'h10 : 5'h08;
            s_nxt.sh    = {s_r.wdata, s_r.wordlen[di] ? s_r.second : 8'h00};
            s_nxt.done  = 1'b0;
            s_nxt.skh   = 1'b0;
            s_nxt.st    = S_SEL;
          end
        end
      endcase
    end

    // Serial sequencer: data changes on the falling half, input is taken with it
    if (tick) begin
      case (s_r.st)
        S_SEL: begin
          s_nxt.skh = 1'b1;
          s_nxt.st  = S_HI;
        end
        S_HI: begin
          s_nxt.skh  = 1'b0;
          s_nxt.sh   = {s_r.sh[14:0], p.si};
          s_nxt.bits = s_r.bits - 5'h01;
          s_nxt.st   = (s_r.bits == 5'h01) ? S_END : S_LO;
        end
        S_LO: begin
          s_nxt.skh = 1'b1;
          s_nxt.st  = S_HI;
        end
        S_END: begin
          if (s_r.len16) begin
            s_nxt.first  = s_r.sh[15:8];
            s_nxt.second = s_r.sh[7:0];
          end else begin
            s_nxt.first = s_r.sh[7:0];
          end
          s_nxt.done = 1'b1;
          s_nxt.irq  = 1'b1;
          s_nxt.hw   = 1'b0;
          s_nxt.st   = S_IDLE;
        end
        default: s_nxt.st = S_IDLE;
      endcase
    end

    // Registered pin drive
    for (int i = 0; i < 8; i++) begin
      s_nxt.sel_o[i] = s_nxt.selport[i] & ~(s_nxt.hw && s_nxt.dev == 3'(i));
    end
    s_nxt.sel_oe = ~s_nxt.pindef;
    s_nxt.sk_o   = s_nxt.skh ^ s_nxt.polar[s_nxt.dev];
    s_nxt.so     = s_nxt.sh[15];
    s_nxt.irq_oe = s_nxt.fmt_done & ~s_nxt.mux & s_nxt.inten & s_nxt.irq;

    // Master reset pin: everything but the synchronisers returns to reset
    if (!p.mrst_n) begin
      s_nxt     = ST_RST;
      s_nxt.sy1 = raw;
      s_nxt.sy2 = s_r.sy1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> host_bus_end.sv
// Host end: runs register reads and writes on the bridge's parallel bus pins.
// Assumes board straps are static and command strobes come from logic on clk.
`default_nettype none

module host_bus_end
  import serial_bridge_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       resetn,
  // Bus pins
  serial_bridge_if.host   bus,
  // Board straps and master reset request
  input  wire logic       mux_board,
  input  wire logic       moto_board,
  input  wire logic       bus_reset_req,
  // Command port
  input  wire logic [3:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic            cmd_busy,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  // Interrupt seen on the format pin
  output logic            irq_n
);

  typedef struct packed {
    logic [7:0]  ad1;
    logic [7:0]  ad2;
    logic        f1;
    logic        f2;
    host_state_e st;
    logic [7:0]  cnt;
    logic        is_rd;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        busy;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  ad_o;
    logic        ad_oe;
    logic [3:0]  a_o;
    logic        ce_n;
    logic        wr;
    logic        rd;
    logic        as;
    logic        mrst_n;
    logic        fmt_oe;
  } host_s;

  host_s s_r;
  host_s s_nxt;

  assign bus.ad_host_o            = s_r.ad_o;
  assign bus.ad_host_oe           = s_r.ad_oe;
  assign bus.addr_lines           = s_r.a_o;
  assign bus.chip_en_n            = s_r.ce_n;
  assign bus.wr_pin               = s_r.wr;
  assign bus.read_or_data_strobe  = s_r.rd;
  assign bus.addr_strobe_bus_type = s_r.as;
  assign bus.master_reset_n       = s_r.mrst_n;
  assign bus.fmt_host_oe          = s_r.fmt_oe;
  assign cmd_busy                 = s_r.busy;
  assign rd_data                  = s_r.rdata;
  assign rd_valid                 = s_r.rvalid;
  assign irq_n                    = s_r.f2;

  always_comb begin
    logic last;
    last = (s_r.cnt == 8'(HOST_PHASE_CYC - 1));
    s_nxt = s_r;
    s_nxt.ad1    = bus.ad;
    s_nxt.ad2    = s_r.ad1;
    s_nxt.f1     = bus.bus_format_irq_pin;
    s_nxt.f2     = s_r.f1;
    s_nxt.rvalid = 1'b0;
    s_nxt.cnt    = last ? 8'h00 : s_r.cnt + 8'h01;
    s_nxt.mrst_n = ~bus_reset_req;
    s_nxt.fmt_oe = mux_board;
    case (s_r.st)
      H_IDLE: begin
        s_nxt.cnt   = 8'h00;
        s_nxt.ce_n  = 1'b1;
        s_nxt.ad_oe = 1'b0;
        s_nxt.rd    = moto_board ? 1'b0 : 1'b1;
        s_nxt.wr    = 1'b1;
        s_nxt.as    = mux_board ? 1'b0 : ~moto_board;
        if (cmd_wr || cmd_rd) begin
          s_nxt.busy  = 1'b1;
          s_nxt.is_rd = cmd_rd & ~cmd_wr;
          s_nxt.addr  = cmd_addr;
          s_nxt.wdata = cmd_wdata;
          s_nxt.a_o   = mux_board ? 4'h0 : cmd_addr;
          s_nxt.ce_n  = 1'b0;
          s_nxt.st    = mux_board ? H_ALE : H_GAP;
        end
      end
      H_ALE: begin
        s_nxt.as    = 1'b1;
        s_nxt.ad_o  = {4'h0, s_r.addr};
        s_nxt.ad_oe = 1'b1;
        if (last) s_nxt.st = H_GAP;
      end
      H_GAP: begin
        s_nxt.as    = mux_board ? 1'b0 : ~moto_board;
        s_nxt.ad_oe = ~s_r.is_rd;
        s_nxt.ad_o  = s_r.wdata;
        s_nxt.wr    = s_r.is_rd;
        if (last) s_nxt.st = H_STB;
      end
      H_STB: begin
        if (moto_board) begin
          s_nxt.rd = 1'b1;
        end else begin
          s_nxt.rd = ~s_r.is_rd;
          s_nxt.wr = s_r.is_rd;
        end
        if (last) begin
          s_nxt.rdata = s_r.ad2;
          s_nxt.st    = H_REC;
        end
      end
      H_REC: begin
        s_nxt.rd = moto_board ? 1'b0 : 1'b1;
        s_nxt.wr = moto_board ? s_r.is_rd : 1'b1;
        if (last) begin
          s_nxt.ce_n   = 1'b1;
          s_nxt.ad_oe  = 1'b0;
          s_nxt.wr     = 1'b1;
          s_nxt.busy   = 1'b0;
          s_nxt.rvalid = s_r.is_rd;
          s_nxt.st     = H_IDLE;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: H_IDLE, ce_n: 1'b1, wr: 1'b1, rd: 1'b1, mrst_n: 1'b1, f1: 1'b1, f2: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> serial_bridge_asserts.sv
// Concurrent checks on the carrier between the host end and the device end.
// Assumes it sees the carrier signals with the shared clock and reset.
`default_nettype none

module serial_bridge_asserts (
  // System
  input wire logic       clk,
  input wire logic       resetn,
  // Carrier
  input wire logic       chip_en_n,
  input wire logic       ad_host_oe,
  input wire logic       ad_dev_oe,
  input wire logic [7:0] ad_dev_o,
  input wire logic       addr_strobe_bus_type,
  input wire logic       master_reset_n,
  input wire logic       fmt_host_oe,
  input wire logic       fmt_dev_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Bus ownership
  dev_quiet_a: assert property (chip_en_n [*5] |-> !ad_dev_oe) else $error("device drives while deselected");
  one_driver_a: assert property (!(ad_dev_oe && ad_host_oe)) else $error("both ends drive data");
  sel_drive_a: assert property ($rose(ad_dev_oe) |-> $past(chip_en_n, 2) == 1'b0) else $error("drive without select");
  host_sel_a: assert property (chip_en_n |-> !ad_host_oe) else $error("host drives while deselected");
  addr_phase_a: assert property (fmt_host_oe && addr_strobe_bus_type |-> ad_host_oe) else $error("no address");
  read_hold_a: assert property ($rose(ad_dev_oe) |=> (ad_dev_oe && $stable(ad_dev_o)) [*3]) else $error("short read");

  // ==========================================================
  // Interrupt and master reset
  irq_mode_a: assert property (fmt_dev_oe |-> !fmt_host_oe) else $error("interrupt on shared bus");
  irq_hold_a: assert property (@(posedge clk) disable iff (!resetn || !master_reset_n)
    $rose(fmt_dev_oe) |-> fmt_dev_oe [*8]) else $error("interrupt dropped early");
  mreset_a: assert property (!master_reset_n [*5] |-> !ad_dev_oe && !fmt_dev_oe) else $error("master reset");

  // ==========================================================
  // Scenario coverage
  cover property ($rose(fmt_dev_oe));
  cover property ($rose(ad_dev_oe));
  cover property (fmt_host_oe && addr_strobe_bus_type);
  cover property (!master_reset_n);
endmodule

`default_nettype wire

// >>> testbench.sv
// Self-checking bench joining the host end and the device end.
// Assumes both ends share one 250 MHz clock.
`default_nettype none

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s: expected %h seen %h", n, e, g); end end

module testbench
  import serial_bridge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, resetn, mux_board, moto_board, mux_moto_style, bus_reset_req;
  logic [3:0]  cmd_addr;
  logic [7:0]  cmd_wdata, rd_data, sel_o, sel_oe, sel_i, rdv, sel_low;
  logic        cmd_wr, cmd_rd, cmd_busy, rd_valid, irq_n, sk, so, si, sk_d;
  logic [15:0] cap;
  int          bad_count, check_count, nbits, cyc, last_rise, per;

  serial_bridge_if bif ();
  host_bus_end host_bus_end_i (.clk(clk), .resetn(resetn), .bus(bif), .mux_board(mux_board),
    .moto_board(moto_board), .bus_reset_req(bus_reset_req), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_busy(cmd_busy), .rd_data(rd_data), .rd_valid(rd_valid), .irq_n(irq_n));
  serial_periph_bridge_dev serial_periph_bridge_dev_i (.clk(clk), .resetn(resetn), .bus(bif),
    .mux_moto_style(mux_moto_style), .peripheral_select_pins_o(sel_o), .peripheral_select_pins_oe(sel_oe),
    .peripheral_select_pins_i(sel_i), .serial_shift_clock(sk), .serial_out(so), .serial_in(si));
  serial_bridge_asserts serial_bridge_asserts_i (.clk(clk), .resetn(resetn), .chip_en_n(bif.chip_en_n),
    .ad_host_oe(bif.ad_host_oe), .ad_dev_oe(bif.ad_dev_oe), .ad_dev_o(bif.ad_dev_o),
    .addr_strobe_bus_type(bif.addr_strobe_bus_type), .master_reset_n(bif.master_reset_n),
    .fmt_host_oe(bif.fmt_host_oe), .fmt_dev_oe(bif.fmt_dev_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Serial monitor: bits, period and lowest select levels per transfer
  always @(posedge clk) begin
    sk_d <= sk;
    cyc <= cyc + 1;
    sel_low <= cmd_wr ? 8'hff : (sel_low & sel_o);
    if (cmd_wr) nbits <= 0;
    else if (sk && !sk_d) begin
      nbits <= nbits + 1;
      cap <= {cap[14:0], so};
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  // ==========================================================
  // Shared tasks
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task op(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cmd_addr <= a; cmd_wdata <= d; cmd_wr <= w; cmd_rd <= !w;
    @(posedge clk);
    cmd_wr <= 1'b0; cmd_rd <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (cmd_busy === 1'b0) break;
    end
    rdv = rd_data;
    if (n == 200) begin bad_count++; end_sim(); end
    `CHK("read valid", !w, rd_valid)
  endtask

  task rd_exp(input string nm, input logic [3:0] a, input logic [7:0] e);
    op(1'b0, a, 8'h00);
    `CHK(nm, e, rdv)
  endtask

  task xfer(input logic [3:0] a, input logic [7:0] d, input logic busy_chk);
    int n;
    op(1'b1, a, d);
    for (n = 0; n < 300; n++) begin
      op(1'b0, A_STATUS, 8'h00);
      if (busy_chk && n == 0) `CHK("done during shift", 1'b0, rdv[STATUS_DONE_BIT])
      if (rdv[STATUS_DONE_BIT] === 1'b1) break;
    end
    if (n == 300) begin bad_count++; end_sim(); end
  endtask

  task do_reset(input logic m, input logic mo);
    resetn <= 1'b0; mux_board <= m; moto_board <= mo; mux_moto_style <= mo;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task t_sw();
    rd_exp("status", A_STATUS, 8'h80);
    rd_exp("rate", A_RATE, 8'h00);
    rd_exp("pin read", A_SELPORT, 8'h5a);
    op(1'b1, A_PINDEF, 8'h00); op(1'b1, A_SELPORT, 8'hf7); op(1'b1, A_RATE, 8'h01);
    `CHK("select pins", 8'hf7, sel_o)
    op(1'b1, A_WORDLEN, 8'h80); op(1'b1, A_SECOND, 8'h34); si <= 1'b1;
    xfer(A_FIRST, 8'h12, 1'b1);
    `CHK("bit count", 16, nbits)
    `CHK("sent word", 16'h1234, cap)
    rd_exp("first", A_FIRST, 8'hff);
    rd_exp("second", A_SECOND, 8'hff);
    `CHK("select kept", 8'hf7, sel_o)
    $display("test software select done");
  endtask

  task t_hw();
    logic [7:0] wl;
    wl = 8'h24;
    op(1'b1, A_SELPORT, 8'hff); op(1'b1, A_WORDLEN, wl);
    for (int d = 0; d < 8; d++) begin
      si <= d[0];
      xfer(A_ALIAS0 + 4'(d), 8'ha5 ^ 8'(d), 1'b0);
      `CHK("select low", ~(8'h01 << d), sel_low)
      `CHK("select released", 8'hff, sel_o)
      `CHK("bit count", wl[d] ? 16 : 8, nbits)
      `CHK("sent byte", 8'ha5 ^ 8'(d), wl[d] ? cap[15:8] : cap[7:0])
      rd_exp("shared first", A_FIRST, {8{d[0]}});
    end
    $display("test hardware select done");
  endtask

  task t_rate();
    op(1'b1, A_WORDLEN, 8'h00);
    for (int c = 0; c < 8; c++) begin
      op(1'b1, A_RATE, {5'h00, 3'(c)});
      xfer(A_FIRST, 8'h5c, 1'b0);
      `CHK("sk period", (c == 0) ? 2 : (1 << c), per)
    end
    $display("test rate done");
  endtask

  task irq_try(input logic exp_low);
    int n;
    op(1'b1, A_RATE, 8'h80);
    op(1'b1, A_FIRST, 8'h3c);
    for (n = 0; n < 300 && !(irq_n === 1'b0 && bif.fmt_dev_oe === 1'b1); n++) @(posedge clk);
    `CHK("format pin", 1'b0, irq_n)
    `CHK("irq drive", exp_low, bif.fmt_dev_oe)
    rd_exp("status", A_STATUS, 8'h80);
    repeat (4) @(posedge clk);
    `CHK("irq cleared", exp_low, irq_n)
    `CHK("irq drive off", 1'b0, bif.fmt_dev_oe)
  endtask

  task t_mreset();
    op(1'b1, A_PINDEF, 8'h00); op(1'b1, A_SELPORT, 8'h0f);
    op(1'b1, A_POLAR, 8'h80);
    `CHK("sk idle inverted", 1'b1, sk)
    bus_reset_req <= 1'b1;
    repeat (6) @(posedge clk);
    bus_reset_req <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("pins released", 8'h00, sel_oe)
    `CHK("sk idle after reset", 1'b0, sk)
    rd_exp("status", A_STATUS, 8'h80);
    rd_exp("pin read", A_SELPORT, 8'h5a);
    $display("test master reset done");
  endtask

  task t_formats();
    for (int f = 0; f < 4; f++) begin
      do_reset(f[1], f[0]);
      op(1'b1, A_SECOND, 8'h30 | 8'(f));
      rd_exp("format data", A_SECOND, 8'h30 | 8'(f));
      irq_try(!f[1]);
    end
    $display("test formats done");
  endtask

  initial begin
    resetn = 1'b0; mux_board = 1'b0; moto_board = 1'b0; mux_moto_style = 1'b0; bus_reset_req = 1'b0;
    cmd_addr = 4'h0; cmd_wdata = 8'h00; cmd_wr = 1'b0; cmd_rd = 1'b0; sel_i = 8'h5a; si = 1'b0;
    sel_low = 8'hff; cap = 16'h0000; nbits = 0; cyc = 0; last_rise = 0; per = 0; sk_d = 1'b0;
    do_reset(1'b0, 1'b0);
    t_sw();
    t_hw();
    t_rate();
    t_mreset();
    t_formats();
    end_sim();
  end
endmodule

`default_nettype wire
